// file: pkg/sebf_consts.svh
// Purpose: shared constants of the serial memory bus slave front end
// Assumes: 20 MHz system clock on both ends
// Notes:   offsets, field positions, reset values and timing counts
//
// Functional notes
// - reset while supply low, standby when high
// - ready for commands within 1 ms
// - filter glitches up to 100 ns
// - undriven protect and strap inputs read low
// - protect input high blocks all writes
// - sample on rising, change on falling, open-drain
// - master makes clock, start and stop
// - zero pulls low, one releases line
// - master starts only on idle bus; sebf_master starts on command without sensing the bus
// - data stable while clock high, else condition
// - start is data falling, clock high
// - stop is data rising, ends command
// - eight-bit address, msb first, type match
// - extension bits match straps or address memory
// - last address bit: 1 read, 0 write
// - acknowledge matching address in ninth clock
// - acknowledge address and data bytes on write
// - read: eight bits, release ninth, continue
// - master ends read with nack, stop
// - busy write cycle: release, ignore requests
// - sample protect before first data byte
`ifndef SEBF_CONSTS_SVH
`define SEBF_CONSTS_SVH

// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define SEBF_CLK_NS        50
`define SEBF_GLITCH_NS     100
`define SEBF_GLITCH_CYC    ((`SEBF_GLITCH_NS + `SEBF_CLK_NS - 1) / `SEBF_CLK_NS)
`define SEBF_PU_MS         1
`define SEBF_PU_CYC        ((`SEBF_PU_MS * 1000000) / `SEBF_CLK_NS)
`define SEBF_SCL_HALF_NS   5000
`define SEBF_SCL_HALF_CYC  ((`SEBF_SCL_HALF_NS + `SEBF_CLK_NS - 1) / `SEBF_CLK_NS)

// --------------------------------------------------------------------
// address byte
// --------------------------------------------------------------------
// type code value is arbitrary
`define SEBF_TYPE_CODE     4'h5
`define SEBF_DENSITY_KB    2

// --------------------------------------------------------------------
// controller registers and fields
// --------------------------------------------------------------------
`define SEBF_REG_CMD       4'h0
`define SEBF_REG_TX        4'h4
`define SEBF_REG_STAT      4'h8
`define SEBF_CMD_START     0
`define SEBF_CMD_STOP      1
`define SEBF_CMD_WRITE     2
`define SEBF_CMD_READ      3
`define SEBF_CMD_NACK      4
`define SEBF_STAT_BUSY     0
`define SEBF_STAT_NACK     1
`define SEBF_STAT_RX_LSB   8
`define SEBF_TX_RESET      8'h00

`endif

// file: pkg/sebf_pkg.sv
// Purpose: types of the serial memory bus slave front end
// Assumes: nothing beyond the consts header
// Notes:   one state struct per end
package sebf_pkg;

    // ----------------------------------------------------------------
    // device end
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEBF_D_IDLE = 3'b000,
        SEBF_D_RECV = 3'b001,
        SEBF_D_ACK  = 3'b010,
        SEBF_D_SEND = 3'b011,
        SEBF_D_MACK = 3'b100,
        SEBF_D_IGN  = 3'b101
    } sebf_dstate_type;

    typedef struct packed {
        logic [1:0]      ln_s1;
        logic [1:0]      ln_s2;
        logic [1:0]      ln_f;
        logic [1:0]      ln_q;
        logic [3:0]      fcnt;
        logic [4:0]      pin_s1;
        logic [4:0]      pin_s2;
        logic [14:0]     pu_cnt;
        logic            ready;
        sebf_dstate_type st;
        logic [3:0]      bitc;
        logic [1:0]      phase;
        logic [7:0]      sh;
        logic            rw;
        logic            m_ack;
        logic            wp_lat;
        logic            any_wr;
        logic            sda_oe_n;
        logic            sda_o;
        logic [2:0]      mem_hi;
        logic [7:0]      maddr;
        logic [7:0]      wdata;
        logic            wr;
        logic            addr_ld;
        logic            rd_next;
        logic            commit;
    } sebf_dev_type;

    // ----------------------------------------------------------------
    // master end
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SEBF_M_IDLE = 2'b00,
        SEBF_M_STA  = 2'b01,
        SEBF_M_BIT  = 2'b10,
        SEBF_M_STO  = 2'b11
    } sebf_mstate_type;

    typedef struct packed {
        logic            sda_s1;
        logic            sda_s2;
        sebf_mstate_type st;
        logic [1:0]      ph;
        logic [7:0]      tmr;
        logic [3:0]      bitn;
        logic            wr_op;
        logic            nack_cfg;
        logic [7:0]      tx;
        logic [7:0]      rx;
        logic            nack_rx;
        logic            scl_oe_n;
        logic            scl_o;
        logic            sda_oe_n;
        logic            sda_o;
        logic            ack;
        logic [31:0]     dat;
    } sebf_mst_type;

endpackage

// file: pkg/sebf_if.sv
// Purpose: two-wire bus joining master and memory front end
// Assumes: pull-ups on both lines
// Notes:   each line low when any party enables a low drive
`timescale 1ns/1ps
interface sebf_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic scl;
    logic sda;

    // wired-and with pull-up
    assign scl = ~(~m_scl_oe_n & ~m_scl_o);
    assign sda = ~(~m_sda_oe_n & ~m_sda_o) & ~(~d_sda_oe_n & ~d_sda_o);

    modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input sda);
    modport device (output d_sda_o, d_sda_oe_n, input scl, sda);
endinterface

// file: rtl/sebf_device.sv
// Purpose: slave front end of a small serial memory
// Assumes: memory array and write engine sit on the user side
// Notes:   mem_rdata_i must always show the byte at the current address
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "sebf_consts.svh"
module sebf_device #(
    parameter int         PU_CYC     = `SEBF_PU_CYC,
    parameter int         DENSITY_KB = `SEBF_DENSITY_KB,
    parameter logic [3:0] TYPE_CODE  = `SEBF_TYPE_CODE  // arbitrary value
) (
    // clock, reset, enable
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // bus
    sebf_if.device          bus,
    // pins
    input  wire logic       supply_ok_i,
    input  wire logic [2:0] strap_i,
    input  wire logic       wp_i,
    // memory side
    input  wire logic       busy_i,
    input  wire logic [7:0] mem_rdata_i,
    output logic            ready_o,
    output logic [2:0]      mem_hi_o,
    output logic [7:0]      mem_addr_o,
    output logic            addr_load_o,
    output logic [7:0]      mem_wdata_o,
    output logic            mem_wr_o,
    output logic            rd_next_o,
    output logic            commit_o
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam logic [14:0] PU_LAST = 15'(PU_CYC - 1);
    localparam logic [1:0]  FLT_MAX = 2'(`SEBF_GLITCH_CYC);
    localparam logic [2:0]  MEM_MASK = (DENSITY_KB >= 16) ? 3'h7 :
                                       (DENSITY_KB >= 8)  ? 3'h3 :
                                       (DENSITY_KB >= 4)  ? 3'h1 : 3'h0;

    sebf_pkg::sebf_dev_type s;
    sebf_pkg::sebf_dev_type n;

    // drive bit b: zero pulls low, one releases
    function automatic logic drv_oe_n(input logic b);
        drv_oe_n = b;
    endfunction

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic id_ok;

    // ----------------------------------------------------------------
    // conditions on filtered lines
    // ----------------------------------------------------------------
    assign scl_rise = s.ln_f[1] & ~s.ln_q[1];
    assign scl_fall = ~s.ln_f[1] & s.ln_q[1];
    assign start_c  = s.ln_f[1] & s.ln_q[1] & s.ln_q[0] & ~s.ln_f[0];
    assign stop_c   = s.ln_f[1] & s.ln_q[1] & ~s.ln_q[0] & s.ln_f[0];
    // ext bits compared with straps only where not used as memory address
    assign id_ok    = (s.sh[7:4] == TYPE_CODE) &&
                      ((s.sh[3:1] & ~MEM_MASK) == (s.pin_s2[2:0] & ~MEM_MASK));

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        n.wr      = 1'b0;
        n.addr_ld = 1'b0;
        n.rd_next = 1'b0;
        n.commit  = 1'b0;
        n.sda_o   = 1'b0;
        // two-flop sync of bus lines and pins; pads pull straps and wp low
        n.ln_s1  = {bus.scl, bus.sda};
        n.ln_s2  = s.ln_s1;
        n.pin_s1 = {supply_ok_i, wp_i, strap_i};
        n.pin_s2 = s.pin_s1;
        n.ln_q   = s.ln_f;
        // a change must persist longer than the glitch window to be taken
        for (int i = 0; i < 2; i++) begin
            if (s.ln_s2[i] == s.ln_f[i]) begin
                n.fcnt[2*i +: 2] = 2'h0;
            end else if (s.fcnt[2*i +: 2] == FLT_MAX) begin
                n.fcnt[2*i +: 2] = 2'h0;
                n.ln_f[i]        = s.ln_s2[i];
            end else begin
                n.fcnt[2*i +: 2] = s.fcnt[2*i +: 2] + 2'h1;
            end
        end
        // power-up delay before the first command
        if (!s.ready) begin
            if (s.pu_cnt == PU_LAST) begin
                n.ready = 1'b1;
            end else begin
                n.pu_cnt = s.pu_cnt + 15'h1;
            end
        end
        if (!s.ready) begin
            n.st = sebf_pkg::SEBF_D_IDLE;
        end else if (start_c) begin
            n.st       = sebf_pkg::SEBF_D_RECV;
            n.bitc     = 4'h0;
            n.phase    = 2'h0;
            n.wp_lat   = 1'b0;
            n.any_wr   = 1'b0;
            n.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            n.st       = sebf_pkg::SEBF_D_IDLE;
            n.sda_oe_n = 1'b1;
            n.commit   = s.any_wr;
        end else if (scl_rise) begin
            case (s.st)
                sebf_pkg::SEBF_D_RECV: begin
                    n.sh   = {s.sh[6:0], s.ln_f[0]};
                    n.bitc = s.bitc + 4'h1;
                end
                sebf_pkg::SEBF_D_MACK: begin
                    n.m_ack = ~s.ln_f[0];
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (s.st)
                sebf_pkg::SEBF_D_RECV: begin
                    if (s.bitc == 4'h8) begin
                        n.st = sebf_pkg::SEBF_D_IGN;
                        if (s.phase == 2'h0) begin
                            // busy write cycle answers nothing
                            if (id_ok && !busy_i) begin
                                n.rw       = s.sh[0];
                                n.mem_hi   = s.sh[3:1] & MEM_MASK;
                                n.phase    = 2'h1;
                                n.st       = sebf_pkg::SEBF_D_ACK;
                                n.sda_oe_n = drv_oe_n(1'b0);
                            end
                        end else if (s.phase == 2'h1) begin
                            n.maddr    = s.sh;
                            n.addr_ld  = 1'b1;
                            n.phase    = 2'h2;
                            n.st       = sebf_pkg::SEBF_D_ACK;
                            n.sda_oe_n = drv_oe_n(1'b0);
                        end else if (!s.wp_lat) begin
                            n.wdata    = s.sh;
                            // protect input is strobed once per write, not again per byte
                            n.phase    = 2'h3;
                            n.wr       = 1'b1;
                            n.any_wr   = 1'b1;
                            n.st       = sebf_pkg::SEBF_D_ACK;
                            n.sda_oe_n = drv_oe_n(1'b0);
                        end
                        // protected: no ack, write dropped, wait for stop
                    end
                end
                sebf_pkg::SEBF_D_ACK: begin
                    n.bitc = 4'h0;
                    if (s.rw) begin
                        n.st       = sebf_pkg::SEBF_D_SEND;
                        n.sh       = mem_rdata_i;
                        n.sda_oe_n = drv_oe_n(mem_rdata_i[7]);
                    end else begin
                        n.st       = sebf_pkg::SEBF_D_RECV;
                        n.sda_oe_n = 1'b1;
                        // this edge precedes the first data byte
                        if (s.phase == 2'h2) begin
                            n.wp_lat = s.pin_s2[3];
                        end
                    end
                end
                sebf_pkg::SEBF_D_SEND: begin
                    if (s.bitc == 4'h7) begin
                        n.st       = sebf_pkg::SEBF_D_MACK;
                        n.sda_oe_n = 1'b1;
                        n.rd_next  = 1'b1;
                        n.bitc     = 4'h0;
                    end else begin
                        n.sh       = {s.sh[6:0], 1'b0};
                        n.sda_oe_n = drv_oe_n(s.sh[6]);
                        n.bitc     = s.bitc + 4'h1;
                    end
                end
                sebf_pkg::SEBF_D_MACK: begin
                    if (s.m_ack) begin
                        n.st       = sebf_pkg::SEBF_D_SEND;
                        n.sh       = mem_rdata_i;
                        n.sda_oe_n = drv_oe_n(mem_rdata_i[7]);
                    end else begin
                        n.st = sebf_pkg::SEBF_D_IGN;
                    end
                end
                default: begin
                end
            endcase
        end
        // brown-out returns everything to reset
        if (!s.pin_s2[4]) begin
            n        = '0;
            n.ln_s1  = {bus.scl, bus.sda};
            n.ln_s2  = s.ln_s1;
            n.ln_f   = 2'h3;
            n.ln_q   = 2'h3;
            n.pin_s1 = {supply_ok_i, wp_i, strap_i};
            n.pin_s2 = s.pin_s1;
            n.sda_oe_n = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.ln_s1    <= 2'h3;
            s.ln_s2    <= 2'h3;
            s.ln_f     <= 2'h3;
            s.ln_q     <= 2'h3;
            s.sda_oe_n <= 1'b1;
        end else if (ce_i) begin
            s <= n;
        end
    end

    // outputs straight from state flops
    assign bus.d_sda_o    = s.sda_o;
    assign bus.d_sda_oe_n = s.sda_oe_n;
    assign ready_o        = s.ready;
    assign mem_hi_o       = s.mem_hi;
    assign mem_addr_o     = s.maddr;
    assign addr_load_o    = s.addr_ld;
    assign mem_wdata_o    = s.wdata;
    assign mem_wr_o       = s.wr;
    assign rd_next_o      = s.rd_next;
    assign commit_o       = s.commit;

endmodule

// file: rtl/sebf_master.sv
// Purpose: two-wire bus master with a classic Wishbone register port
// Assumes: slave never stretches the clock
// Notes:   one bus operation per command write
`timescale 1ns/1ps
`include "sebf_consts.svh"
module sebf_master (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // bus
    sebf_if.master           bus,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam logic [7:0] HALF_LAST = 8'(`SEBF_SCL_HALF_CYC - 1);

    sebf_pkg::sebf_mst_type s;
    sebf_pkg::sebf_mst_type n;
    logic req;
    logic tick;
    logic bitval;

    assign req  = wb_cyc_i & wb_stb_i & ~s.ack;
    assign tick = (s.tmr == HALF_LAST);
    // ninth bit: release for slave ack on write, own ack on read
    assign bitval = (s.bitn == 4'h8) ? (s.wr_op | s.nack_cfg) :
                    (s.wr_op ? s.tx[3'(4'h7 - s.bitn)] : 1'b1);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n        = s;
        n.sda_s1 = bus.sda;
        n.sda_s2 = s.sda_s1;
        n.scl_o  = 1'b0;
        n.sda_o  = 1'b0;
        n.ack    = req;
        n.tmr    = (s.st == sebf_pkg::SEBF_M_IDLE || tick) ? 8'h00 : s.tmr + 8'h01;
        // register port
        n.dat = 32'h0;
        if (req && !wb_we_i && wb_adr_i == `SEBF_REG_STAT) begin
            n.dat[`SEBF_STAT_BUSY]             = (s.st != sebf_pkg::SEBF_M_IDLE);
            n.dat[`SEBF_STAT_NACK]             = s.nack_rx;
            n.dat[`SEBF_STAT_RX_LSB +: 8]      = s.rx;
        end else if (req && !wb_we_i && wb_adr_i == `SEBF_REG_TX) begin
            n.dat[7:0] = s.tx;
        end
        if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SEBF_REG_TX) begin
            n.tx = wb_dat_i[7:0];
        end
        // commands ignored while an operation runs
        if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `SEBF_REG_CMD &&
            s.st == sebf_pkg::SEBF_M_IDLE) begin
            n.ph       = 2'h0;
            n.bitn     = 4'h0;
            n.nack_cfg = wb_dat_i[`SEBF_CMD_NACK];
            if (wb_dat_i[`SEBF_CMD_START]) begin
                n.st = sebf_pkg::SEBF_M_STA;
            end else if (wb_dat_i[`SEBF_CMD_WRITE] | wb_dat_i[`SEBF_CMD_READ]) begin
                n.st    = sebf_pkg::SEBF_M_BIT;
                n.wr_op = wb_dat_i[`SEBF_CMD_WRITE];
            end else if (wb_dat_i[`SEBF_CMD_STOP]) begin
                n.st = sebf_pkg::SEBF_M_STO;
            end
        end
        // bus sequencer, one phase per half clock period
        case (s.st)
            sebf_pkg::SEBF_M_STA: begin
                // software issues start only after stop and bus-free time
                n.sda_oe_n = (s.ph == 2'h0);
                n.scl_oe_n = (s.ph != 2'h2);
                if (tick) begin
                    n.ph = s.ph + 2'h1;
                    if (s.ph == 2'h2) begin
                        n.st = sebf_pkg::SEBF_M_IDLE;
                    end
                end
            end
            sebf_pkg::SEBF_M_BIT: begin
                n.scl_oe_n = (s.ph == 2'h1);
                n.sda_oe_n = bitval;
                if (tick) begin
                    if (s.ph == 2'h0) begin
                        n.ph = 2'h1;
                    end else begin
                        n.ph   = 2'h0;
                        n.bitn = s.bitn + 4'h1;
                        if (s.bitn == 4'h8) begin
                            n.nack_rx  = s.sda_s2;
                            n.scl_oe_n = 1'b0;
                            n.st       = sebf_pkg::SEBF_M_IDLE;
                        end else begin
                            n.rx = {s.rx[6:0], s.sda_s2};
                        end
                    end
                end
            end
            sebf_pkg::SEBF_M_STO: begin
                n.sda_oe_n = (s.ph == 2'h2);
                n.scl_oe_n = (s.ph != 2'h0);
                if (tick) begin
                    n.ph = s.ph + 2'h1;
                    if (s.ph == 2'h2) begin
                        n.st = sebf_pkg::SEBF_M_IDLE;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.sda_s1   <= 1'b1;
            s.sda_s2   <= 1'b1;
            s.scl_oe_n <= 1'b1;
            s.sda_oe_n <= 1'b1;
            s.tx       <= `SEBF_TX_RESET;
        end else if (ce_i) begin
            s <= n;
        end
    end

    assign bus.m_scl_o    = s.scl_o;
    assign bus.m_scl_oe_n = s.scl_oe_n;
    assign bus.m_sda_o    = s.sda_o;
    assign bus.m_sda_oe_n = s.sda_oe_n;
    assign wb_dat_o       = s.dat;
    assign wb_ack_o       = s.ack;

endmodule

// file: sim/sebf_link_props.sv
// Purpose: link checks on the two wires
// Assumes: 20 MHz clock, 100 kHz link
// Notes:   sees wires only
`timescale 1ns/1ps
module sebf_link_props (
    // clock, reset, wires
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic m_scl_o,
    input wire logic m_scl_oe_n,
    input wire logic m_sda_o,
    input wire logic d_sda_o,
    input wire logic d_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // data moving while clock high marks a condition
    sequence start_seq; scl && $past(scl) && $fell(sda); endsequence
    sequence stop_seq; scl && $past(scl) && $rose(sda); endsequence
    a_open_drain: assert property (!m_scl_o && !m_sda_o && !d_sda_o) else $error("line driven high");
    a_reset_release: assert property ($fell(rst_i) |-> d_sda_oe_n && m_scl_oe_n) else $error("held");
    a_start_hold: assert property (start_seq |=> scl [*8]) else $error("start short");
    a_stop_idle: assert property (stop_seq |=> (sda && d_sda_oe_n) [*8]) else $error("busy after stop");
    a_dev_quiet_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n)) else $error("moved");
    a_dev_edge_low: assert property ($changed(d_sda_oe_n) |-> !scl && !$past(scl, 3)) else $error("early");
    a_ack_held: assert property ($fell(d_sda_oe_n) |=> !d_sda_oe_n [*8]) else $error("ack short");
    a_scl_high: assert property ($rose(m_scl_oe_n) |=> m_scl_oe_n [*8]) else $error("clock high short");
endmodule

// file: sim/sebf_tb.sv
// Purpose: bench for master and memory end on one link
// Assumes: power-up delay cut to 20 cycles
// Notes:   all traffic goes through the master registers
`timescale 1ns/1ps
module sebf_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic        ack, ready, wr_p, cm_p, ld_p, rn_p;
    logic        supply = 1'b1;
    logic [2:0]  mhi;
    logic [2:0]  strap = 3'h0;
    logic        wp = 1'b0;
    logic        busy = 1'b0;
    logic [7:0]  maddr, wdata;
    int          err_total = 0, num_checks = 0, cycles = 0, wr_cnt = 0, cm_cnt = 0, ld_cnt = 0, rn_cnt = 0;
    sebf_if bi();
    sebf_master i_sebf_master (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .bus(bi), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i({4{cyc}}), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    // read data steps with each rd_next pulse, so a second byte must be reloaded
    sebf_device #(.PU_CYC(20), .DENSITY_KB(4)) i_sebf_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .bus(bi),
        .supply_ok_i(supply), .strap_i(strap), .wp_i(wp), .busy_i(busy), .mem_rdata_i(8'h96 + 8'(rn_cnt)),
        .ready_o(ready), .mem_hi_o(mhi), .mem_addr_o(maddr), .addr_load_o(ld_p), .mem_wdata_o(wdata),
        .mem_wr_o(wr_p), .rd_next_o(rn_p), .commit_o(cm_p));
    sebf_link_props i_sebf_link_props (.clk_i(clk_i), .rst_i(rst_i), .m_scl_o(bi.m_scl_o), .m_scl_oe_n(bi.m_scl_oe_n),
        .m_sda_o(bi.m_sda_o), .d_sda_o(bi.d_sda_o), .d_sda_oe_n(bi.d_sda_oe_n), .scl(bi.scl), .sda(bi.sda));
    always #25 clk_i = ~clk_i;
    // pulse counters and hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        wr_cnt <= wr_cnt + int'(wr_p === 1'b1);
        cm_cnt <= cm_cnt + int'(cm_p === 1'b1);
        ld_cnt <= ld_cnt + int'(ld_p === 1'b1);
        rn_cnt <= rn_cnt + int'(rn_p === 1'b1);
        if (cycles == 90000) begin
            err_total++;
            conclude();
        end
    end
    task automatic conclude;
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // one classic cycle; request held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    // command, then poll status until idle
    task automatic cmd(input logic [4:0] c);
        wb(1'b1, 4'h0, {27'h0, c});
        do wb(1'b0, 4'h8, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic xfer(input logic [7:0] b, input logic n);
        wb(1'b1, 4'h4, {24'h0, b});
        cmd(5'h04);
        chk({31'h0, q[1]}, {31'h0, n});
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, ready}, 32'h0);
        wait (ready === 1'b1);
        cmd(5'h01);
        xfer(8'h52, 1'b0);
        xfer(8'h3C, 1'b0);
        xfer(8'hA5, 1'b0);
        cmd(5'h02);
        wait (cm_cnt == 1);
        chk({24'h0, maddr}, 32'h3C);
        chk({24'h0, wdata}, 32'hA5);
        chk({29'h0, mhi}, 32'h1);
        // foreign type, strap mismatch, then protected write
        cmd(5'h01);
        xfer(8'h90, 1'b1);
        strap <= 3'h2;
        wp <= 1'b1;
        cmd(5'h01);
        xfer(8'h50, 1'b1);
        cmd(5'h01);
        xfer(8'h54, 1'b0);
        xfer(8'h3C, 1'b0);
        xfer(8'h11, 1'b1);
        cmd(5'h02);
        wp <= 1'b0;
        // read: master ack, then nack
        cmd(5'h01);
        xfer(8'h55, 1'b0);
        cmd(5'h08);
        chk({24'h0, q[15:8]}, 32'h96);
        cmd(5'h18);
        chk({24'h0, q[15:8]}, 32'h97);
        cmd(5'h02);
        busy <= 1'b1;
        cmd(5'h01);
        xfer(8'h54, 1'b1);
        cmd(5'h02);
        chk(wr_cnt, 32'h1);
        chk(cm_cnt, 32'h1);
        chk(ld_cnt, 32'h2);
        chk(rn_cnt, 32'h2);
        // brown-out: device back to reset, then ready and answering again
        busy <= 1'b0;
        supply <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({31'h0, ready}, 32'h0);
        supply <= 1'b1;
        wait (ready === 1'b1);
        cmd(5'h01);
        xfer(8'h54, 1'b0);
        cmd(5'h02);
        conclude();
    end
endmodule
